// File: common/ies_pkg.sv
package ies_pkg;
    // Register bus
    localparam int                 ADDR_W         = 32;
    localparam logic [31:0]        SEL_HIGH_ADDR  = 32'h019C_0000;
    localparam logic [31:0]        SEL_LOW_ADDR   = 32'h019C_0004;
    localparam int                 CODE_W         = 5;
    localparam int                 NUM_SEL        = 12;
    localparam int                 NUM_CPU_IRQ    = 16;
    localparam int                 NUM_CHAN       = 64;
    // Field low bit positions, selector 0 = interrupt 4 ... 11 = 15
    localparam int                 FIELD_LSB [12] = '{0, 5, 10, 16, 21, 26,
                                                      0, 5, 10, 16, 21, 26};
    // Writable bit masks: bits 15 and 31 hold nothing
    localparam logic [31:0]        SEL_MASK       = 32'h7FFF_7FFF;
    // Reset values (interrupts 4..9 low, 10..15 high)
    localparam logic [31:0]        SEL_LOW_RST    = 32'h2507_18A4;
    localparam logic [31:0]        SEL_HIGH_RST   = 32'h0820_2D43;
    // Source codes
    localparam logic [4:0] SRC_HOST     = 5'h00;
    localparam logic [4:0] SRC_TMR0     = 5'h01;
    localparam logic [4:0] SRC_TMR1     = 5'h02;
    localparam logic [4:0] SRC_MEMA     = 5'h03;
    localparam logic [4:0] SRC_GPIO4    = 5'h04;
    localparam logic [4:0] SRC_DMA      = 5'h08;
    localparam logic [4:0] SRC_EMU_DMA  = 5'h09;
    localparam logic [4:0] SRC_EMU_RX   = 5'h0A;
    localparam logic [4:0] SRC_EMU_TX   = 5'h0B;
    localparam logic [4:0] SRC_SER0_TX  = 5'h0C;
    localparam logic [4:0] SRC_SER0_RX  = 5'h0D;
    localparam logic [4:0] SRC_SER1_TX  = 5'h0E;
    localparam logic [4:0] SRC_SER1_RX  = 5'h0F;
    localparam logic [4:0] SRC_GPIO0    = 5'h10;
    localparam logic [4:0] SRC_SER2_TX  = 5'h11;
    localparam logic [4:0] SRC_SER2_RX  = 5'h12;
    localparam logic [4:0] SRC_TMR2     = 5'h13;
    localparam logic [4:0] SRC_MEMB     = 5'h14;
    localparam logic [4:0] SRC_CELL     = 5'h17;
    localparam logic [4:0] SRC_VIT      = 5'h1E;
    localparam logic [4:0] SRC_TURBO    = 5'h1F;

    // Peripheral event and interrupt lines
    typedef struct packed {
        logic        host_irq;
        logic        timer0_expiry;
        logic        timer1_expiry;
        logic        timer2_expiry;
        logic        memory_a_refresh_tick;
        logic        memory_b_refresh_tick;
        logic [15:0] gpio_event;
        logic        serial0_tx_event;
        logic        serial0_rx_event;
        logic        serial1_tx_event;
        logic        serial1_rx_event;
        logic        serial2_tx_event;
        logic        serial2_rx_event;
        logic        viterbi_rx_event;
        logic        viterbi_tx_event;
        logic        turbo_rx_event;
        logic        turbo_tx_event;
        logic        cell_rx_event;
        logic        cell_tx_event;
    } ies_evt_t;

    typedef struct packed {
        logic serial0_tx_irq;
        logic serial0_rx_irq;
        logic serial1_tx_irq;
        logic serial1_rx_irq;
        logic serial2_tx_irq;
        logic serial2_rx_irq;
        logic dma_completion_irq;
        logic emulation_dma_irq;
        logic emulation_exchange_rx_irq;
        logic emulation_exchange_tx_irq;
        logic cell_port_irq;
        logic viterbi_irq;
        logic turbo_irq;
    } ies_irq_t;
endpackage

// File: core/ies_src_mux.sv
`timescale 1ns/1ps
`default_nettype none
// Decodes one 5-bit selector code to its interrupt source
module ies_src_mux (
    // Selection
    input  wire logic [4:0]        code,
    // Sources
    input  wire ies_pkg::ies_evt_t evt,
    input  wire ies_pkg::ies_irq_t irq,
    // Result
    output logic                   hit
);
    // Reserved codes yield no source
    always_comb begin
        unique case (code)
            ies_pkg::SRC_HOST:    hit = evt.host_irq;
            ies_pkg::SRC_TMR0:    hit = evt.timer0_expiry;
            ies_pkg::SRC_TMR1:    hit = evt.timer1_expiry;
            ies_pkg::SRC_MEMA:    hit = evt.memory_a_refresh_tick;
            5'h04:                hit = evt.gpio_event[4];
            5'h05:                hit = evt.gpio_event[5];
            5'h06:                hit = evt.gpio_event[6];
            5'h07:                hit = evt.gpio_event[7];
            ies_pkg::SRC_DMA:     hit = irq.dma_completion_irq;
            ies_pkg::SRC_EMU_DMA: hit = irq.emulation_dma_irq;
            ies_pkg::SRC_EMU_RX:  hit = irq.emulation_exchange_rx_irq;
            ies_pkg::SRC_EMU_TX:  hit = irq.emulation_exchange_tx_irq;
            ies_pkg::SRC_SER0_TX: hit = irq.serial0_tx_irq;
            ies_pkg::SRC_SER0_RX: hit = irq.serial0_rx_irq;
            ies_pkg::SRC_SER1_TX: hit = irq.serial1_tx_irq;
            ies_pkg::SRC_SER1_RX: hit = irq.serial1_rx_irq;
            ies_pkg::SRC_GPIO0:   hit = evt.gpio_event[0];
            ies_pkg::SRC_SER2_TX: hit = irq.serial2_tx_irq;
            ies_pkg::SRC_SER2_RX: hit = irq.serial2_rx_irq;
            ies_pkg::SRC_TMR2:    hit = evt.timer2_expiry;
            ies_pkg::SRC_MEMB:    hit = evt.memory_b_refresh_tick;
            ies_pkg::SRC_CELL:    hit = irq.cell_port_irq;
            ies_pkg::SRC_VIT:     hit = irq.viterbi_irq;
            ies_pkg::SRC_TURBO:   hit = irq.turbo_irq;
            default:              hit = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// File: core/ies_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
module ies_top (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    // Register port
    input  wire logic [31:0]         reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    // Peripheral sources
    input  wire ies_pkg::ies_evt_t   evt_in,
    input  wire ies_pkg::ies_irq_t   irq_in,
    input  wire logic                nmi_in,
    input  wire logic [63:0]         chain_evt,
    // DMA controller side
    input  wire logic [63:0]         event_enable,
    input  wire logic [63:0]         flag_clear,
    input  wire logic [63:0]         flag_set,
    output logic      [31:0]         event_flag_low,
    output logic      [31:0]         event_flag_high,
    output logic      [63:0]         dma_req,
    // CPU side
    output logic      [15:0]         cpu_irq
);

    // ========================================================
    // Channel event map
    logic [63:0] chan_src;

    // Fixed wiring, not programmable
    always_comb begin
        chan_src        = 64'h0;
        chan_src[0]     = evt_in.host_irq;
        chan_src[1]     = evt_in.timer0_expiry;
        chan_src[2]     = evt_in.timer1_expiry;
        chan_src[3]     = evt_in.memory_a_refresh_tick;
        chan_src[7:4]   = evt_in.gpio_event[7:4];
        chan_src[11:8]  = evt_in.gpio_event[3:0];
        chan_src[12]    = evt_in.serial0_tx_event;
        chan_src[13]    = evt_in.serial0_rx_event;
        chan_src[14]    = evt_in.serial1_tx_event;
        chan_src[15]    = evt_in.serial1_rx_event;
        chan_src[17]    = evt_in.serial2_tx_event;
        chan_src[18]    = evt_in.serial2_rx_event;
        chan_src[19]    = evt_in.timer2_expiry;
        chan_src[20]    = evt_in.memory_b_refresh_tick;
        chan_src[28]    = evt_in.viterbi_rx_event;
        chan_src[29]    = evt_in.viterbi_tx_event;
        chan_src[30]    = evt_in.turbo_rx_event;
        chan_src[31]    = evt_in.turbo_tx_event;
        chan_src[32]    = evt_in.cell_rx_event;
        chan_src[40]    = evt_in.cell_tx_event;
        chan_src[55:48] = evt_in.gpio_event[15:8];
    end

    // ========================================================
    // Event flags
    logic [63:0] trig;
    logic [63:0] flag_r;
    logic [63:0] flag_nxt;

    // Completion chaining ORs into any channel
    assign trig = chan_src | chain_evt | flag_set;

    // Set beats clear; enables do not gate capture
    always_comb begin
        flag_nxt = (flag_r & ~flag_clear) | trig;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            flag_r <= 64'h0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign event_flag_low  = flag_r[31:0];
    assign event_flag_high = flag_r[63:32];
    // Priority ordering lives in the DMA parameter memory, downstream
    assign dma_req         = flag_r & event_enable;

    // ========================================================
    // Selector registers
    logic [31:0] sel_hi_r;
    logic [31:0] sel_hi_nxt;
    logic [31:0] sel_lo_r;
    logic [31:0] sel_lo_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        hit_hi;
    logic        hit_lo;

    assign hit_hi = (reg_addr == ies_pkg::SEL_HIGH_ADDR);
    assign hit_lo = (reg_addr == ies_pkg::SEL_LOW_ADDR);

    // Gap bits masked off so they read zero
    always_comb begin
        sel_hi_nxt = sel_hi_r;
        sel_lo_nxt = sel_lo_r;
        rdata_nxt  = 32'h0;
        if (reg_wr && hit_hi) begin
            sel_hi_nxt = reg_wdata & ies_pkg::SEL_MASK;
        end
        if (reg_wr && hit_lo) begin
            sel_lo_nxt = reg_wdata & ies_pkg::SEL_MASK;
        end
        if (reg_rd && hit_hi) begin
            rdata_nxt = sel_hi_r;
        end else if (reg_rd && hit_lo) begin
            rdata_nxt = sel_lo_r;
        end
    end

    // Defaults select the documented sources
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sel_hi_r <= ies_pkg::SEL_HIGH_RST;
            sel_lo_r <= ies_pkg::SEL_LOW_RST;
            rdata_r  <= 32'h0;
        end else begin
            sel_hi_r <= sel_hi_nxt;
            sel_lo_r <= sel_lo_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ========================================================
    // CPU interrupt front end
    logic [11:0] sel_hit;
    logic [15:0] irq_nxt;
    logic [15:0] irq_r;

    // One decoder per maskable interrupt
    generate
        for (genvar i = 0; i < ies_pkg::NUM_SEL; i++) begin : g_sel
            logic [4:0] code;
            // Lower register serves 4-9, upper serves 10-15
            if (i < 6) begin : g_lo
                assign code = sel_lo_r[ies_pkg::FIELD_LSB[i] +: 5];
            end else begin : g_hi
                assign code = sel_hi_r[ies_pkg::FIELD_LSB[i] +: 5];
            end
            ies_src_mux u_mux (
                .code (code),
                .evt  (evt_in),
                .irq  (irq_in),
                .hit  (sel_hit[i])
            );
        end
    endgenerate

    // Slot 0 reset, 1 NMI, 2-3 reserved and held low
    always_comb begin
        irq_nxt        = 16'h0;
        irq_nxt[0]     = ~rst_b;
        irq_nxt[1]     = nmi_in;
        irq_nxt[15:4]  = sel_hit;
    end

    // Registered to keep the CPU input glitch free
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_r <= 16'h0001;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign cpu_irq = irq_r;

    // ========================================================
    // Checks
    property p_flag_capture;
        @(posedge ref_clk) disable iff (!rst_b)
        chan_src[5] |=> flag_r[5];
    endproperty
    flag_capture_a: assert property (p_flag_capture)
        else $error("event not latched");

    property p_flag_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        (flag_r[13] && !flag_clear[13]) |=> flag_r[13];
    endproperty
    flag_hold_a: assert property (p_flag_hold)
        else $error("flag lost without clear");

    property p_gpio_hi;
        @(posedge ref_clk) disable iff (!rst_b)
        evt_in.gpio_event[8] |=> event_flag_high[16];
    endproperty
    gpio_high_a: assert property (p_gpio_hi)
        else $error("gpio 8 not on channel 48");

    property p_empty_chan;
        @(posedge ref_clk) disable iff (!rst_b)
        1'b1 |-> (chan_src[21] == 1'b0) && (chan_src[63:56] == 8'h00);
    endproperty
    empty_chan_a: assert property (p_empty_chan)
        else $error("unconnected channel driven");

    property p_gap_bits;
        @(posedge ref_clk) disable iff (!rst_b)
        1'b1 |-> !sel_hi_r[15] && !sel_hi_r[31]
            && !sel_lo_r[15] && !sel_lo_r[31];
    endproperty
    gap_bits_a: assert property (p_gap_bits)
        else $error("gap bit set");

    property p_reserved_low;
        @(posedge ref_clk) disable iff (!rst_b)
        ##1 (cpu_irq[3:2] == 2'b00);
    endproperty
    reserved_low_a: assert property (p_reserved_low)
        else $error("reserved interrupt raised");

    property p_nmi_path;
        @(posedge ref_clk) disable iff (!rst_b)
        nmi_in |=> cpu_irq[1];
    endproperty
    nmi_path_a: assert property (p_nmi_path)
        else $error("nmi not forwarded");

    property p_read_back;
        @(posedge ref_clk) disable iff (!rst_b)
        (reg_rd && hit_lo) |=> (reg_rdata == $past(sel_lo_r));
    endproperty
    read_back_a: assert property (p_read_back)
        else $error("read data mismatch");

    property p_int14_default;
        @(posedge ref_clk) disable iff (!rst_b)
        (sel_hi_r[25:21] == ies_pkg::SRC_TMR0 && evt_in.timer0_expiry)
            |=> cpu_irq[14];
    endproperty
    int14_default_a: assert property (p_int14_default)
        else $error("timer 0 not routed to interrupt 14");

    property p_chain;
        @(posedge ref_clk) disable iff (!rst_b)
        chain_evt[60] |=> flag_r[60];
    endproperty
    chain_trig_a: assert property (p_chain)
        else $error("chain event not captured");

    property p_host_chan;
        @(posedge ref_clk) disable iff (!rst_b)
        evt_in.host_irq |=> event_flag_low[0];
    endproperty
    host_chan_a: assert property (p_host_chan)
        else $error("host event not on channel 0");

    property p_gpio_low;
        @(posedge ref_clk) disable iff (!rst_b)
        evt_in.gpio_event[0] |=> event_flag_low[8];
    endproperty
    gpio_low_a: assert property (p_gpio_low)
        else $error("gpio 0 not on channel 8");

    property p_timer2_chan;
        @(posedge ref_clk) disable iff (!rst_b)
        evt_in.timer2_expiry |=> event_flag_low[19];
    endproperty
    timer2_chan_a: assert property (p_timer2_chan)
        else $error("timer 2 not on channel 19");

    property p_cell_tx;
        @(posedge ref_clk) disable iff (!rst_b)
        evt_in.cell_tx_event |=> event_flag_high[8];
    endproperty
    cell_tx_a: assert property (p_cell_tx)
        else $error("cell transmit not on channel 40");

    property p_capture_off;
        @(posedge ref_clk) disable iff (!rst_b)
        (chan_src[12] && !event_enable[12]) |=> event_flag_low[12];
    endproperty
    capture_off_a: assert property (p_capture_off)
        else $error("disabled event not latched");

    property p_flag_clear;
        @(posedge ref_clk) disable iff (!rst_b)
        (flag_clear[13] && !trig[13]) |=> !flag_r[13];
    endproperty
    flag_clear_a: assert property (p_flag_clear)
        else $error("flag not cleared");

    property p_rdata_idle;
        @(posedge ref_clk) disable iff (!rst_b)
        !reg_rd |=> (reg_rdata == 32'h0);
    endproperty
    rdata_idle_a: assert property (p_rdata_idle)
        else $error("read data outside read cycle");

    property p_read_high;
        @(posedge ref_clk) disable iff (!rst_b)
        (reg_rd && hit_hi) |=> (reg_rdata == $past(sel_hi_r));
    endproperty
    read_high_a: assert property (p_read_high)
        else $error("high read data mismatch");

    property p_write_low;
        @(posedge ref_clk) disable iff (!rst_b)
        (reg_wr && hit_lo)
            |=> (sel_lo_r == ($past(reg_wdata) & ies_pkg::SEL_MASK));
    endproperty
    write_low_a: assert property (p_write_low)
        else $error("low selector write lost");

    property p_reset_slot;
        @(posedge ref_clk) disable iff (!rst_b)
        rst_b |=> !cpu_irq[0];
    endproperty
    reset_slot_a: assert property (p_reset_slot)
        else $error("reset interrupt stuck high");

    property p_int4_default;
        @(posedge ref_clk) disable iff (!rst_b)
        (sel_lo_r[4:0] == ies_pkg::SRC_GPIO4 && evt_in.gpio_event[4])
            |=> cpu_irq[4];
    endproperty
    int4_default_a: assert property (p_int4_default)
        else $error("gpio 4 not routed to interrupt 4");

    property p_ser0_tx;
        @(posedge ref_clk) disable iff (!rst_b)
        (sel_lo_r[4:0] == ies_pkg::SRC_SER0_TX && irq_in.serial0_tx_irq)
            |=> cpu_irq[4];
    endproperty
    ser0_tx_a: assert property (p_ser0_tx)
        else $error("serial 0 transmit not routed");
endmodule
`default_nettype wire

// File: verification/ies_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// DMA channel controller stand-in
module ies_dma_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Pace: high holds each request off for four cycles
    input  wire logic        slow,
    // Channel side
    input  wire logic [63:0] dma_req,
    output logic      [63:0] flag_clear
);
    logic [2:0] wait_r;
    logic [2:0] wait_nxt;
    logic       go;

    // Serve every raised request at once; slow mode lets flags stand
    always_comb begin
        go         = (dma_req != 64'h0) && (wait_r >= (slow ? 3'h4 : 3'h0));
        flag_clear = go ? dma_req : 64'h0;
        wait_nxt   = (dma_req == 64'h0 || go) ? 3'h0 : wait_r + 3'h1;
    end

    // Service delay counter
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wait_r <= 3'h0;
        end else begin
            wait_r <= wait_nxt;
        end
    end
endmodule
`default_nettype wire

// File: verification/tb_ies_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ies_top;
    logic              ref_clk;
    logic              rst_b;
    logic [31:0]       reg_addr;
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [31:0]       reg_rdata;
    ies_pkg::ies_evt_t evt_in;
    ies_pkg::ies_irq_t irq_in;
    logic              nmi_in;
    logic              slow;
    logic [63:0]       chain_evt;
    logic [63:0]       event_enable;
    logic [63:0]       flag_clear;
    logic [63:0]       flag_set;
    logic [63:0]       dma_req;
    logic [31:0]       event_flag_low;
    logic [31:0]       event_flag_high;
    logic [15:0]       cpu_irq;
    logic [31:0]       rd_val;
    logic [63:0]       flags_all;
    logic [4:0]        sel [12];
    int                fails;
    int                n_compared;
    int                f;
    localparam int     CH_LO [12] = '{40, 32, 31, 30, 29, 28,
                                      18, 17, 15, 14, 13, 12};
    localparam int     CH_HI [6]  = '{20, 3, 19, 2, 1, 0};

    // ============================================================
    // Design and far-side model
    ies_top DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .evt_in(evt_in), .irq_in(irq_in),
        .nmi_in(nmi_in), .chain_evt(chain_evt),
        .event_enable(event_enable), .flag_clear(flag_clear),
        .flag_set(flag_set), .event_flag_low(event_flag_low),
        .event_flag_high(event_flag_high), .dma_req(dma_req),
        .cpu_irq(cpu_irq));
    ies_dma_model dma_far (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow),
        .dma_req(dma_req), .flag_clear(flag_clear));

    // All 64 flags as one word
    assign flags_all = {event_flag_high, event_flag_low};

    // ============================================================
    // Helpers
    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test;
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Bus cycles leave one idle edge so a strobe is never set twice
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge ref_clk);
    endtask

    function automatic logic [31:0] pack(input int hi);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < 6; i++) begin
            r[ies_pkg::FIELD_LSB[i] +: 5] = sel[i + 6 * hi];
        end
        return r;
    endfunction

    function automatic logic [15:0] exp_irq(input int c);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 12; i++) r[i + 4] = (sel[i] == c[4:0]);
        return r;
    endfunction

    function automatic int chan_of(input int b);
        if (b < 12) return CH_LO[b];
        if (b < 16) return b - 4;
        if (b < 20) return b - 12;
        if (b < 28) return b + 28;
        return CH_HI[b - 28];
    endfunction

    // Sources behind each selector code
    task automatic drive_src(input int c, input logic v);
        case (c)
            0: evt_in.host_irq <= v;
            1: evt_in.timer0_expiry <= v;
            2: evt_in.timer1_expiry <= v;
            3: evt_in.memory_a_refresh_tick <= v;
            4, 5, 6, 7: evt_in.gpio_event[c] <= v;
            8: irq_in.dma_completion_irq <= v;
            9: irq_in.emulation_dma_irq <= v;
            10: irq_in.emulation_exchange_rx_irq <= v;
            11: irq_in.emulation_exchange_tx_irq <= v;
            12: irq_in.serial0_tx_irq <= v;
            13: irq_in.serial0_rx_irq <= v;
            14: irq_in.serial1_tx_irq <= v;
            15: irq_in.serial1_rx_irq <= v;
            16: evt_in.gpio_event[0] <= v;
            17: irq_in.serial2_tx_irq <= v;
            18: irq_in.serial2_rx_irq <= v;
            19: evt_in.timer2_expiry <= v;
            20: evt_in.memory_b_refresh_tick <= v;
            23: irq_in.cell_port_irq <= v;
            30: irq_in.viterbi_irq <= v;
            default: irq_in.turbo_irq <= v;
        endcase
    endtask

    // Enable all channels and let the far side clear every flag;
    // requests are seen before the far side can clear them
    task automatic drain(input logic [63:0] e);
        int k;
        event_enable <= '1;
        #1 chk("dma_req", e, dma_req);
        k = 0;
        while (flags_all !== 64'h0 && k < 20) begin
            @(posedge ref_clk);
            #1 k++;
        end
        if (k >= 20) begin
            chk("flags_drained", 64'h0, flags_all);
            stop_test();
        end
        @(posedge ref_clk);
        event_enable <= '0;
    endtask

    // ============================================================
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ============================================================
    // Main sequence
    initial begin
        {rst_b, reg_wr, reg_rd, nmi_in, slow} = 5'h00;
        {reg_addr, reg_wdata} = 64'h0;
        {chain_evt, event_enable, flag_set} = '0;
        evt_in = '0;
        irq_in = '0;
        sel = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1 chk("cpu_irq_rst", 64'h1, cpu_irq);
        @(posedge ref_clk);
        // Selector defaults, map and gap bits
        rd_reg(32'h019C_0000, rd_val);
        chk("sel_high", pack(1), rd_val);
        rd_reg(32'h019C_0004, rd_val);
        chk("sel_low", pack(0), rd_val);
        wr_reg(32'h019C_0008, 32'hFFFF_FFFF);
        rd_reg(32'h019C_0008, rd_val);
        chk("unmapped", 64'h0, rd_val);
        rd_reg(32'h019C_0000, rd_val);
        chk("sel_high", 32'h0820_2D43, rd_val);
        wr_reg(32'h019C_0004, 32'hFFFF_FFFF);
        rd_reg(32'h019C_0004, rd_val);
        chk("gap_bits", 32'h7FFF_7FFF, rd_val);
        wr_reg(32'h019C_0004, pack(0));
        // Every fixed event lands on its own channel only
        for (int b = 0; b < 34; b++) begin
            slow <= b[0];
            evt_in <= ies_pkg::ies_evt_t'(34'h1 << b);
            @(posedge ref_clk);
            evt_in <= '0;
            #1 chk("flags", 64'h1 << chan_of(b), flags_all);
            chk("dma_req_off", 64'h0, dma_req);
            @(posedge ref_clk);
            drain(64'h1 << chan_of(b));
        end
        // Chaining triggers on unconnected channels, then manual set
        chain_evt <= 64'h9000_0000_0020_0000;
        @(posedge ref_clk);
        chain_evt <= '0;
        flag_set  <= 64'h0000_0000_0001_0000;
        #1 chk("chain_flags", 64'h9000_0000_0020_0000, flags_all);
        @(posedge ref_clk);
        flag_set <= '0;
        drain(64'h9000_0000_0021_0000);
        // Non-maskable input, every selected source idle
        nmi_in <= 1'b1;
        @(posedge ref_clk);
        #1 chk("cpu_irq_nmi", 64'h2, cpu_irq);
        @(posedge ref_clk);
        nmi_in <= 1'b0;
        // Every usable code through a rotating field
        for (int c = 0; c < 32; c++) begin
            if (c == 21 || c == 22 || (c >= 24 && c <= 29)) continue;
            f = c % 12;
            sel[f] = c[4:0];
            wr_reg(f < 6 ? 32'h019C_0004 : 32'h019C_0000, pack(f < 6 ? 0 : 1));
            drive_src(c, 1'b1);
            @(posedge ref_clk);
            #1 chk("cpu_irq", exp_irq(c), cpu_irq);
            @(posedge ref_clk);
            drive_src(c, 1'b0);
            @(posedge ref_clk);
        end
        stop_test();
    end
endmodule
`default_nettype wire
